// *** rtl/dtec_pkg.sv ***
// Constants, types and register map of the dual timer/event counter
package dtec_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CNT0 = 8'h0d;
  localparam logic [7:0] IDX_CTL0 = 8'h0e;
  localparam logic [7:0] IDX_CNT1 = 8'h10;
  localparam logic [7:0] IDX_CTL1 = 8'h11;
  localparam logic [7:0] IDX_PORTA = 8'h12;
  localparam logic [7:0] IDX_IRQA = 8'h20;
  localparam logic [7:0] IDX_IRQB = 8'h21;
  localparam logic [7:0] IDX_CFG = 8'h22;
  // Interrupt control bit positions
  localparam int IRQA_EN0_BIT = 3;
  localparam int IRQA_FLAG0_BIT = 6;
  localparam int IRQB_EN1_BIT = 0;
  localparam int IRQB_FLAG1_BIT = 4;
  // Configuration option bit positions
  localparam int CFG_DIV_SRC_BIT = 0;
  localparam int CFG_PIN_DIV_BIT = 1;
  localparam int CFG_C0_DIV4_BIT = 2;
  localparam int CFG_C1_SRC_LO = 4;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int PA3_BIT = 3;
  localparam logic PA3_RST = 1'b1;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_TOP = 8'hff;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  // Counter 1 option clock sources
  localparam logic [1:0] C1SRC_OVF0 = 2'h0;
  localparam logic [1:0] C1SRC_SYS = 2'h1;
  localparam logic [1:0] C1SRC_TBASE = 2'h2;

  typedef enum logic [1:0] {
    MODE_UNUSED = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } dtec_mode_t;

  // Control byte bits 7..3; bits 2..0 read as zero
  typedef struct packed {
    dtec_mode_t mode;
    logic clk_sel;
    logic run;
    logic edge_sel;
  } dtec_ctrl_t;

  localparam dtec_ctrl_t CTRL_RST = '{MODE_UNUSED, 1'b0, 1'b0, 1'b1};

  typedef enum logic [1:0] {
    PW_WAIT = 2'b01,
    PW_MEAS = 2'b10
  } dtec_pw_t;
endpackage

// *** rtl/dtec_top.sv ***
// Dual 8-bit timer/event counter with divider output, Wishbone slave
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module dtec_top
  import dtec_pkg::*;
(
  input wire logic clk_i, // 25 MHz system clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [9:2] adr_i, // Wishbone word address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic ctr0_pin_i, // External input of counter 0
  input wire logic ctr1_pin_i, // External input of counter 1
  input wire logic rtc_tick_i, // Real time clock tick, one cycle
  input wire logic timebase_tick_i, // Time base time-out, one cycle
  output logic ctr0_irq_req_o, // Counter 0 interrupt request
  output logic ctr1_irq_req_o, // Counter 1 interrupt request
  output logic wake_o, // Wake-up pulse on overflow
  output logic freq_divider_out_o, // Divider square wave
  output logic port_a_pin3_o // Port pin 3 level
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic req;
  logic wr_en;
  logic [7:0] idx;
  logic [7:0] rd;
  logic [7:0] cnt [2];
  logic [7:0] pre [2];
  dtec_ctrl_t ctrl [2];
  logic [1:0] tick;
  logic [1:0] ovf;
  logic [1:0] int_src;
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] presc;
  logic q_tick;
  logic opt1;
  logic [7:0] cfg;
  logic pa3;
  logic flag0;
  logic flag1;
  logic en0;
  logic en1;
  logic div_q;
  logic div_ovf;

  assign idx = adr_i;
  assign req = cyc_i & stb_i;
  // Writes land on the edge where the master sees ack
  assign wr_en = req & we_i & ack_o & sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req & ~ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h00000000;
    else if (req & ~ack_o)
      dat_o <= {24'h000000, rd};
  end

  // Unmapped indices answer with zero data
  always_comb
  begin
    rd = 8'h00;
    case (idx)
      IDX_CNT0: rd = cnt[0];
      IDX_CNT1: rd = cnt[1];
      IDX_CTL0: rd = {ctrl[0], 3'h0};
      IDX_CTL1: rd = {ctrl[1], 3'h0};
      IDX_PORTA: rd = {4'h0, pa3, 3'h0};
      IDX_IRQA: rd = {1'b0, flag0, 2'h0, en0, 3'h0};
      IDX_IRQB: rd = {3'h0, flag1, 3'h0, en1};
      IDX_CFG: rd = cfg;
      default: rd = 8'h00;
    endcase
  end

  // Event pins come from outside; two stages before any use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1 <= 2'h0;
      s2 <= 2'h0;
      s3 <= 2'h0;
    end
    else
    begin
      s1 <= {ctr1_pin_i, ctr0_pin_i};
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      presc <= 2'h0;
    else
      presc <= presc + 2'h1;
  end
  assign q_tick = (presc == PRESC_LAST);

  assign int_src[0] = ctrl[0].clk_sel ?
                      (cfg[CFG_C0_DIV4_BIT] ? q_tick : 1'b1) :
                      rtc_tick_i;

  always_comb
  begin
    opt1 = 1'b0;
    case (cfg[CFG_C1_SRC_LO +: 2])
      C1SRC_OVF0: opt1 = ovf[0];
      C1SRC_SYS: opt1 = 1'b1;
      C1SRC_TBASE: opt1 = timebase_tick_i;
      default: opt1 = 1'b0;
    endcase
  end
  assign int_src[1] = ctrl[1].clk_sel ? q_tick : opt1;

  for (genvar gi = 0; gi < 2; gi++)
  begin : g_ch
    localparam logic [7:0] VAL = (gi == 0) ? IDX_CNT0 : IDX_CNT1;
    localparam logic [7:0] CTL = (gi == 0) ? IDX_CTL0 : IDX_CTL1;
    logic wr_val;
    logic wr_ctl;
    logic rd_blk;
    logic rise;
    logic fall;
    logic ev_edge;
    logic start_e;
    logic stop_e;
    logic is_pulse;
    logic pw_done;
    logic src;
    dtec_pw_t st;

    assign wr_val = wr_en & (idx == VAL);
    assign wr_ctl = wr_en & (idx == CTL);
    // Freezing the count during a read avoids a torn value
    assign rd_blk = req & ~we_i & (idx == VAL);
    assign rise = s2[gi] & ~s3[gi];
    assign fall = ~s2[gi] & s3[gi];
    assign ev_edge = ctrl[gi].edge_sel ? fall : rise;
    assign start_e = ctrl[gi].edge_sel ? rise : fall;
    assign stop_e = ctrl[gi].edge_sel ? fall : rise;
    assign is_pulse = (ctrl[gi].mode == MODE_PULSE);
    assign pw_done = (st == PW_MEAS) & ctrl[gi].run & is_pulse & stop_e;

    always_comb
    begin
      src = 1'b0;
      case (ctrl[gi].mode)
        MODE_EVENT: src = ev_edge;
        MODE_TIMER: src = int_src[gi];
        MODE_PULSE: src = int_src[gi] & (st == PW_MEAS);
        default: src = 1'b0;
      endcase
    end
    // Counts lost while reading are not made up later
    assign tick[gi] = src & ctrl[gi].run & ~rd_blk;
    assign ovf[gi] = tick[gi] & (cnt[gi] == CNT_TOP);

    // Edge-started, single-shot measurement
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        st <= PW_WAIT;
      else
        case (st)
          PW_WAIT:
            if (ctrl[gi].run & is_pulse & start_e & ~wr_ctl)
              st <= PW_MEAS;
          PW_MEAS:
            if (~ctrl[gi].run | ~is_pulse | stop_e)
              st <= PW_WAIT;
          default: st <= PW_WAIT;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cnt[gi] <= CNT_RST;
      else if (wr_val & ~ctrl[gi].run)
        cnt[gi] <= dat_i[7:0];
      else if (ovf[gi])
        cnt[gi] <= pre[gi];
      else if (tick[gi])
        cnt[gi] <= cnt[gi] + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        pre[gi] <= CNT_RST;
      else if (wr_val)
        pre[gi] <= dat_i[7:0];
    end

    // A software write in the same cycle wins over the auto-clear
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        ctrl[gi] <= CTRL_RST;
      else if (wr_ctl)
        ctrl[gi] <= dtec_ctrl_t'(dat_i[7:3]);
      else if (pw_done)
        ctrl[gi].run <= 1'b0;
    end

    sequence s_meas_end;
      (st == PW_MEAS) && ctrl[gi].run && is_pulse && stop_e && !wr_ctl;
    endsequence

    sequence s_event_step;
      ctrl[gi].run && (ctrl[gi].mode == MODE_EVENT) && ev_edge &&
      !rd_blk && !wr_val && (cnt[gi] != CNT_TOP);
    endsequence

    a_pw_self_clear: assert property (
      s_meas_end |=> !ctrl[gi].run && (st == PW_WAIT) && !tick[gi])
      else $error("pulse end did not clear enable");
    a_event_step: assert property (
      s_event_step |=> cnt[gi] == $past(cnt[gi]) + 8'h01)
      else $error("event edge did not advance counter");
    a_ovf_reload: assert property (
      ovf[gi] && !wr_val |=> cnt[gi] == $past(pre[gi]))
      else $error("overflow did not reload counter");
    a_stop_load: assert property (
      wr_val && !ctrl[gi].run |=> cnt[gi] == $past(dat_i[7:0]))
      else $error("preload write while stopped missed counter");
    a_run_keep: assert property (
      wr_val && ctrl[gi].run && !tick[gi] |=> $stable(cnt[gi]))
      else $error("preload write disturbed running counter");
    a_read_freeze: assert property (
      rd_blk ##1 rd_blk |-> $stable(cnt[gi]))
      else $error("counter moved during read");
    a_run_sticky: assert property (
      ctrl[gi].run && !is_pulse && !wr_ctl |=> ctrl[gi].run)
      else $error("enable cleared itself outside pulse mode");
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg <= CFG_RST;
    else if (wr_en & (idx == IDX_CFG))
      cfg <= dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pa3 <= PA3_RST;
    else if (wr_en & (idx == IDX_PORTA))
      pa3 <= dat_i[PA3_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en0 <= 1'b0;
      en1 <= 1'b0;
    end
    else
    begin
      if (wr_en & (idx == IDX_IRQA))
        en0 <= dat_i[IRQA_EN0_BIT];
      if (wr_en & (idx == IDX_IRQB))
        en1 <= dat_i[IRQB_EN1_BIT];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag0 <= 1'b0;
    else if (ovf[0])
      flag0 <= 1'b1;
    else if (wr_en & (idx == IDX_IRQA))
      flag0 <= dat_i[IRQA_FLAG0_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag1 <= 1'b0;
    else if (ovf[1])
      flag1 <= 1'b1;
    else if (wr_en & (idx == IDX_IRQB))
      flag1 <= dat_i[IRQB_FLAG1_BIT];
  end

  assign ctr0_irq_req_o = flag0 & en0;
  assign ctr1_irq_req_o = flag1 & en1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_o <= 1'b0;
    else
      wake_o <= |ovf;
  end

  assign div_ovf = cfg[CFG_DIV_SRC_BIT] ? ovf[1] : ovf[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_q <= 1'b0;
    else if (div_ovf)
      div_q <= ~div_q;
  end
  assign freq_divider_out_o = div_q;

  // Pin holds low when the divider is gated off by a set data bit
  assign port_a_pin3_o = cfg[CFG_PIN_DIV_BIT] ?
                         (~pa3 & div_q) : pa3;

  a_flag_set: assert property (
    ovf[0] |=> flag0 ##0 (wake_o))
    else $error("overflow 0 did not set flag and wake");
  a_irq_gate: assert property (
    !en1 |-> !ctr1_irq_req_o ##1 (!en1 || ctr1_irq_req_o == flag1))
    else $error("disabled interrupt still requested");
  a_div_toggle: assert property (
    div_ovf |=> freq_divider_out_o != $past(freq_divider_out_o))
    else $error("divider did not toggle on overflow");
  a_wake_any: assert property (
    ovf[1] |=> wake_o && flag1)
    else $error("overflow 1 did not wake");
  a_wb_ack: assert property (
    req && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle answer");
endmodule

// *** test/dtec_pin_model.sv ***
// Partner model: drives one external counter input with single pulses
`timescale 1ns/1ps
module dtec_pin_model
(
  input wire logic clk_i, // System clock
  input wire logic go_i, // Start one pulse
  input wire logic pol_i, // Active level of the pulse
  input wire logic [7:0] width_i, // Pulse length in cycles
  output logic pin_o // Driven input level
);
  logic [7:0] left = 8'h00;
  always @(posedge clk_i)
  begin
    if (go_i)
      left <= width_i;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
  // Idle is the inverse level, so every pulse gives two edges
  assign pin_o = (left != 8'h00) ? pol_i : ~pol_i;
endmodule

// *** test/tb_top.sv ***
// Self-checking testbench of the dual timer/event counter
`timescale 1ns/1ps
module tb_top
  import dtec_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack, irq0, irq1, wake, div, pin3, pin0, pin1;
  logic go0 = 1'b0;
  logic go1 = 1'b0;
  logic pol0 = 1'b1;
  logic div_q = 1'b0;
  logic [7:0] wid = 8'h14;
  logic [7:0] q, q2;
  int n_fail = 0;
  int compares = 0;
  int cyc_n = 0;
  int t_last = 0;
  int t_prev = 0;
  int n_wake = 0;
  int n_tog = 0;
  int w, e, wk, tg, pre;
  logic rtc = 1'b0;
  logic tbase = 1'b0;
  int t_tog = 0;
  int t_tpre = 0;
  int exp_w[$];

  always #20 clk = ~clk;

  dtec_top dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(rdat),
    .ack_o(ack), .ctr0_pin_i(pin0), .ctr1_pin_i(pin1),
    .rtc_tick_i(rtc), .timebase_tick_i(tbase), .ctr0_irq_req_o(irq0),
    .ctr1_irq_req_o(irq1), .wake_o(wake), .freq_divider_out_o(div),
    .port_a_pin3_o(pin3));
  dtec_pin_model p0 (.clk_i(clk), .go_i(go0), .pol_i(pol0),
    .width_i(wid), .pin_o(pin0));
  dtec_pin_model p1 (.clk_i(clk), .go_i(go1), .pol_i(1'b1),
    .width_i(wid), .pin_o(pin1));

  // Overflow spacing is judged from wake pulse times
  // Option clock ticks: real time clock every 3, time base every 5 cycles
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    rtc <= (cyc_n % 3 == 0);
    tbase <= (cyc_n % 5 == 0);
    div_q <= div;
    if (div !== div_q)
    begin
      n_tog <= n_tog + 1;
      t_tpre <= t_tog;
      t_tog <= cyc_n;
    end
    if (wake === 1'b1)
    begin
      n_wake <= n_wake + 1;
      t_prev <= t_last;
      t_last <= cyc_n;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Only the watchdog ends a wait for ack
  task wb(input logic w_en, input logic [7:0] i, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= i;
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] i, input logic [7:0] d);
    wb(1'b1, i, d);
  endtask

  task rd(input logic [7:0] i, input logic [7:0] x, input string nm);
    wb(1'b0, i, 8'h00);
    chk({24'h0, q}, {24'h0, x}, nm);
  endtask

  task fire(input logic c);
    if (c)
      go1 <= 1'b1;
    else
      go0 <= 1'b1;
    @(posedge clk);
    go0 <= 1'b0;
    go1 <= 1'b0;
  endtask

  task final_report;
    $display("Checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report;
  end

  initial
  begin
    void'($urandom(97217));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(IDX_CTL0, 8'h08, "ctl0 reset");
    rd(IDX_CTL1, 8'h08, "ctl1 reset");
    rd(IDX_PORTA, 8'h08, "port reset");
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00, "unmapped");
    wr(IDX_CTL0, 8'h18);
    wr(IDX_CTL0, 8'ha0);
    wr(IDX_CNT0, 8'hf0);
    rd(IDX_CNT0, 8'hf0, "preload stopped");
    wr(IDX_CFG, 8'h02);
    wr(IDX_PORTA, 8'h00);
    wk = n_wake;
    tg = n_tog;
    wr(IDX_CTL0, 8'hb0);
    repeat (100)
    begin
      @(posedge clk);
      chk({31'h0, pin3}, {31'h0, div}, "pin3 divider");
    end
    chk(t_last - t_prev, 16, "interval f0");
    chk(n_tog - tg, n_wake - wk, "toggles");
    chk({31'h0, n_wake > wk + 4}, 1, "wakes");
    wr(IDX_CNT0, 8'hf8);
    repeat (60) @(posedge clk);
    chk(t_last - t_prev, 8, "interval f8");
    rd(IDX_CTL0, 8'hb0, "run kept");
    rd(IDX_IRQA, 8'h40, "flag0");
    wr(IDX_CTL0, 8'ha0);
    wb(1'b0, IDX_CNT0, 8'h00);
    q2 = q;
    rd(IDX_CNT0, q2, "halted");
    chk({31'h0, q2 >= 8'hf8}, 1, "reload range");
    chk({31'h0, irq0}, 0, "irq masked");
    wr(IDX_IRQA, 8'h48);
    chk({31'h0, irq0}, 1, "irq on");
    wr(IDX_IRQA, 8'h08);
    chk({31'h0, irq0}, 0, "irq cleared");
    wr(IDX_PORTA, 8'h08);
    chk({31'h0, pin3}, 0, "divider off");
    wr(IDX_CFG, 8'h00);
    chk({31'h0, pin3}, 1, "plain pin");
    // Counter 1 timer on system clock divided by four
    pre = $urandom_range(252, 240);
    wr(IDX_CTL1, 8'ha0);
    wr(IDX_CNT1, pre[7:0]);
    tg = n_tog;
    wr(IDX_CTL1, 8'hb0);
    repeat (200) @(posedge clk);
    chk(t_last - t_prev, 4 * (256 - pre), "ctr1 interval");
    chk(n_tog, tg, "divider source");
    rd(IDX_IRQB, 8'h10, "flag1");
    // Flag bit written back as 1, else the write would clear it
    wr(IDX_IRQB, 8'h11);
    chk({31'h0, irq1}, 1, "irq1 on");
    wr(IDX_CTL1, 8'ha0);
    for (e = 0; e < 2; e++)
    begin
      wr(IDX_CTL1, {2'h1, 2'h0, e[0], 3'h0});
      wr(IDX_CNT1, 8'h00);
      wr(IDX_CTL1, {2'h1, 2'h1, e[0], 3'h0});
      wid <= 8'h14;
      fire(1'b1);
      repeat (10) @(posedge clk);
      rd(IDX_CNT1, {7'h0, ~e[0]}, "rise edge");
      repeat (20) @(posedge clk);
      rd(IDX_CNT1, 8'h01, "fall edge");
    end
    // Pulse width on counter 0; the first pulse is already active at enable
    for (e = 0; e < 2; e++)
    begin
      pol0 <= e[0];
      wr(IDX_CTL0, {2'h3, 2'h2, e[0], 3'h0});
      wr(IDX_CNT0, 8'h00);
      wid <= 8'h32;
      fire(1'b0);
      repeat (5) @(posedge clk);
      wr(IDX_CTL0, {2'h3, 2'h3, e[0], 3'h0});
      repeat (60) @(posedge clk);
      rd(IDX_CNT0, 8'h00, "level start");
      rd(IDX_CTL0, {2'h3, 2'h3, e[0], 3'h0}, "armed");
      w = $urandom_range(60, 20);
      exp_w.push_back(w);
      wid <= w[7:0];
      fire(1'b0);
      repeat (w + 10) @(posedge clk);
      wb(1'b0, IDX_CNT0, 8'h00);
      q2 = q;
      // Both edges see the same synchroniser delay, so the count is exact
      chk({24'h0, q2}, exp_w.pop_front(), "width");
      rd(IDX_CTL0, {2'h3, 2'h2, e[0], 3'h0}, "run cleared");
      fire(1'b0);
      repeat (w + 10) @(posedge clk);
      rd(IDX_CNT0, q2, "held");
    end
    // Option clocks: tick-driven counter 0 cascaded into counter 1
    wr(IDX_CFG, 8'h01);
    wr(IDX_CTL1, 8'h80);
    wr(IDX_CNT1, 8'hfe);
    wr(IDX_CTL0, 8'h80);
    wr(IDX_CNT0, 8'hfc);
    wr(IDX_CTL1, 8'h90);
    wr(IDX_CTL0, 8'h90);
    repeat (120) @(posedge clk);
    chk(t_last - t_prev, 3 * 4, "tick interval");
    chk(t_tog - t_tpre, 3 * 4 * 2, "cascade divider");
    wr(IDX_CTL0, 8'h80);
    wr(IDX_CTL1, 8'h80);
    wr(IDX_CFG, 8'h24);
    wr(IDX_CNT1, 8'hfd);
    wr(IDX_CTL1, 8'h90);
    repeat (120) @(posedge clk);
    chk(t_last - t_prev, 5 * 3, "time base interval");
    wr(IDX_CTL1, 8'h80);
    wr(IDX_CNT0, 8'hf8);
    wr(IDX_CTL0, 8'hb0);
    repeat (120) @(posedge clk);
    chk(t_last - t_prev, 4 * 8, "ctr0 quarter clock");
    final_report;
  end
endmodule
